/* File: dv/urx_line_model.sv */
`timescale 1ns/1ns
module urx_line_model #(
   parameter int BIT_NS = 320
) (
   // serial line
   output logic o_rx
);
   initial o_rx = 1'b1;
   // lsb first nrz frame, optional mid-bit glitch
   task automatic send(input logic [11:0] bits, input int n, input bit glitch);
      #1;
      for (int k = 0; k < n; k++) begin
         o_rx = bits[k];
         if (glitch && k == 1) begin
            #(BIT_NS * 9 / 16);
            o_rx = ~bits[k];
            #(BIT_NS / 16);
            o_rx = bits[k];
            #(BIT_NS * 6 / 16);
         end
         else begin
            #(BIT_NS);
         end
      end
      o_rx = 1'b1;
   endtask
endmodule // urx_line_model

/* File: dv/urx_receiver_bench.sv */
`timescale 1ns/1ns
module urx_receiver_bench;
   localparam int DIV = 2;
   logic        i_sys_clk, i_rx, o_irq, o_break;
   logic        i_rst_n = 1'b0, i_ce = 1'b1, i_rd_en = 1'b0, i_parity_or_ninth_bit = 1'b1;
   logic        i_serial_irq_global_mask = 1'b1, i_irq_full_en = 1'b1;
   logic        i_irq_overrun_en = 1'b1, i_irq_break_en = 1'b1;
   logic [1:0]  i_frame_format_select = 2'h0;
   logic [11:0] i_baud_divisor = DIV;
   logic [7:0]  i_rd_addr = 8'h00, o_rd_data;
   int          mismatches = 0, checked = 0, breaks = 0;
   urx_receiver dut_u (.i_sys_clk, .i_rst_n, .i_ce, .i_rx, .i_frame_format_select, .i_parity_or_ninth_bit,
      .i_baud_divisor, .i_serial_irq_global_mask, .i_irq_full_en, .i_irq_overrun_en, .i_irq_break_en,
      .i_rd_addr, .i_rd_en, .o_rd_data, .o_irq, .o_break);
   urx_line_model #(.BIT_NS(160 * DIV)) line_u (.o_rx(i_rx));
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) if (o_break) breaks++;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge i_sys_clk);
      i_rd_addr <= addr;
      i_rd_en   <= 1'b1;
      @(posedge i_sys_clk);
      i_rd_en <= 1'b0;
      #1 chk($sformatf("reg %h", addr), o_rd_data, exp);
   endtask
   task automatic frame(input logic [11:0] bits, input int n, input bit glitch);
      @(posedge i_sys_clk);
      line_u.send(bits, n, glitch);
      repeat (64) @(posedge i_sys_clk);
   endtask
   task automatic done(input string t);
      $display("test %s finished", t);
   endtask
   task automatic end_of_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      rd(8'h35, 8'h00);
      rd(8'h24, 8'h00);
      rd(8'h10, 8'h00);
      done("reset");
      for (int f = 0; f < 4; f++) begin
         i_frame_format_select <= f[1:0];
         frame({2'b11, f != 2, 8'h96, 1'b0}, f == 0 ? 10 : 11, 1'b0);
         chk("irq", {7'h00, o_irq}, 8'h01);
         rd(8'h35, f == 3 ? 8'h24 : 8'h20);
         rd(8'h24, 8'h96);
         rd(8'h35, f == 3 ? 8'h04 : 8'h00);
      end
      done("formats");
      i_frame_format_select <= 2'h2;
      i_parity_or_ninth_bit <= 1'b0;
      for (int q = 1; q >= 0; q--) begin
         frame({2'b11, q[0], 8'h96, 1'b0}, 11, 1'b0);
         rd(8'h35, q ? 8'h20 : 8'h60);
         rd(8'h24, 8'h96);
      end
      i_frame_format_select <= 2'h0;
      frame({2'b00, 8'h96, 1'b0}, 10, 1'b0);
      rd(8'h35, 8'h60);
      rd(8'h24, 8'h96);
      done("errors");
      frame({2'b11, 8'h55, 1'b0}, 10, 1'b1);
      rd(8'h35, 8'ha0);
      rd(8'h24, 8'h55);
      done("noise");
      i_serial_irq_global_mask <= 1'b0;
      frame({2'b11, 8'h11, 1'b0}, 10, 1'b0);
      frame({2'b11, 8'h22, 1'b0}, 10, 1'b0);
      chk("irq", {7'h00, o_irq}, 8'h00);
      rd(8'h35, 8'h30);
      rd(8'h24, 8'h11);
      done("overrun");
      i_serial_irq_global_mask <= 1'b1;
      frame(12'h000, 12, 1'b0);
      chk("breaks", breaks[7:0], 8'h01);
      done("break");
      end_of_test();
   end
endmodule // urx_receiver_bench

/* File: dv/urx_receiver_chk.sv */
`timescale 1ns/1ns
module urx_receiver_chk (
   // clock and reset
   input logic       i_sys_clk,
   input logic       i_rst_n,
   input logic       i_ce,
   // line and requests
   input logic       i_rx,
   input logic       i_serial_irq_global_mask,
   input logic       i_irq_full_en,
   input logic       i_irq_overrun_en,
   input logic       i_irq_break_en,
   input logic       o_irq,
   input logic       o_break,
   // read port
   input logic [7:0] i_rd_addr,
   input logic       i_rd_en,
   input logic [7:0] o_rd_data
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   wire rd_tk = i_ce && i_rd_en;
   wire rd_st = rd_tk && i_rd_addr == 8'h35;
   wire rd_dt = rd_tk && i_rd_addr == 8'h24;
   unmapped_read_a: assert property (rd_tk && !rd_st && !rd_dt |=> o_rd_data == 8'h00)
      else $error("unmapped read not zero");
   read_hold_a: assert property (!rd_tk |=> $stable(o_rd_data))
      else $error("read data moved without read");
   full_clear_a: assert property (rd_dt ##2 rd_st |=> !o_rd_data[5])
      else $error("full flag kept after data read");
   irq_mask_a: assert property (!i_serial_irq_global_mask |-> !o_irq)
      else $error("request passed closed mask");
   irq_source_a: assert property (!i_irq_full_en && !i_irq_overrun_en && !i_irq_break_en |-> !o_irq)
      else $error("request without enabled source");
   full_irq_a: assert property (i_serial_irq_global_mask && i_irq_full_en && rd_st |=> o_rd_data[5] -> o_irq)
      else $error("full word without request");
   break_pulse_a: assert property (o_break |=> !o_break)
      else $error("break pulse too long");
   break_line_a: assert property (o_break |-> !i_rx && !$past(i_rx, 8))
      else $error("break with line high");
endmodule // urx_receiver_chk
bind urx_receiver urx_receiver_chk chk_u (.i_sys_clk, .i_rst_n, .i_ce, .i_rx, .i_serial_irq_global_mask,
   .i_irq_full_en, .i_irq_overrun_en, .i_irq_break_en, .o_irq, .o_break, .i_rd_addr, .i_rd_en, .o_rd_data);

/* File: shared/urx_consts.vh */
`ifndef URX_CONSTS_VH
`define URX_CONSTS_VH
// register offsets
`define URX_ADDR_DATA      8'h24
`define URX_ADDR_STATUS    8'h35
// status bit positions
`define URX_ST_NINTH       2
`define URX_ST_OVERRUN     4
`define URX_ST_FULL        5
`define URX_ST_FRAME       6
`define URX_ST_NOISE       7
// frame formats
`define URX_FRM_8N1        2'b00
`define URX_FRM_8N2        2'b01
`define URX_FRM_8P1        2'b10
`define URX_FRM_9N1        2'b11
// oversampling
`define URX_OVS            5'd16
`define URX_VOTE_A         4'd7
`define URX_VOTE_B         4'd8
`define URX_VOTE_C         4'd9
`define URX_START_HIGHS    2'd3
`define URX_BREAK_BITS     4'd10
`define URX_STEPS_SHORT    4'd9
`define URX_STEPS_LONG     4'd10
// reset values
`define URX_RST_BYTE       8'h00
`define URX_RST_DIV        12'h000
`endif

/* File: src/urx_receiver.v */
`timescale 1ns/1ns
// Functional notes
// - sixteen samples per bit period
// - start is low after three highs
// - nrz frame, start, 8/9 data, stop
// - four frame formats supported
// - parity checked even or odd
// - ninth bit in status bit 2
// - stop moves word, sets full bit 5
// - data read returns word, clears full
// - unread buffer sets overrun bit 4, kept
// - majority of three samples per bit
// - disagreeing samples set noise bit 7
// - noisy bit does not abort frame
// - nine or ten acquisition steps
// - parity or stop failure sets bit 6
// - ten low bits raise break request
// - format field decode 00..11
// - parity control 0 odd 1 even
// - twelve bit divisor makes sample clock
// - o_irq gated by global mask bit, o_break not gated
module urx_receiver (
   // clock, reset, enable
   input  wire        i_sys_clk,
   input  wire        i_rst_n,
   input  wire        i_ce,
   // serial line
   input  wire        i_rx,
   // configuration
   input  wire [1:0]  i_frame_format_select,
   input  wire        i_parity_or_ninth_bit,
   input  wire [11:0] i_baud_divisor,
   input  wire        i_serial_irq_global_mask,
   input  wire        i_irq_full_en,
   input  wire        i_irq_overrun_en,
   input  wire        i_irq_break_en,
   // core read port
   input  wire [7:0]  i_rd_addr,
   input  wire        i_rd_en,
   output reg  [7:0]  o_rd_data,
   // requests
   output wire        o_irq,
   output reg         o_break
);
`include "urx_consts.vh"
////////////////////////////////////////////////////////////////////////
// line synchroniser
reg rx_m_q;
reg rx_s_q;
always @(posedge i_sys_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
   end else if (i_ce) begin
      rx_m_q <= i_rx;
      rx_s_q <= rx_m_q;
   end
end
////////////////////////////////////////////////////////////////////////
// sample tick
wire tick;
urx_tick_gen u_tick (
   .i_sys_clk (i_sys_clk),
   .i_rst_n   (i_rst_n),
   .i_ce      (i_ce),
   .i_div     (i_baud_divisor),
   .o_tick    (tick)
);
////////////////////////////////////////////////////////////////////////
// receive state machine
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_BIT  = 3'b010;
localparam [2:0] ST_DONE = 3'b100;

function [3:0] steps_for;
   input [1:0] frame_format_select;
   begin
      steps_for = (frame_format_select == `URX_FRM_8N1) ? `URX_STEPS_SHORT : `URX_STEPS_LONG;
   end
endfunction

reg  [2:0] state_q;
reg  [1:0] highs_q;
reg  [3:0] phase_q;
reg  [3:0] step_q;
reg  [2:0] smp_q;
reg  [9:0] shift_q;
reg        noise_q;
reg        ferr_q;
reg  [3:0] lows_q;
reg  [1:0] frm_q;
reg        par_sel_q;
wire       vbit;
wire       vnoisy;
urx_vote u_vote (
   .i_smp   (smp_q),
   .o_bit   (vbit),
   .o_noisy (vnoisy)
);
wire [3:0] nsteps   = steps_for(frm_q);
wire       bit_end  = tick && (state_q == ST_BIT) && (phase_q == 4'hf);
wire       last     = (step_q == nsteps - 4'd1);
// short frames shift nine times, so drop the stale low bit
wire [9:0] word_w   = (nsteps == `URX_STEPS_SHORT) ? {1'b0, shift_q[9:1]} : shift_q;
wire [7:0] data_w   = word_w[7:0];
wire       ninth_w  = word_w[8];
wire       par_ok   = ((^word_w[8:0]) == ~par_sel_q);
wire       stop1_ok = (frm_q == `URX_FRM_8N1) ? word_w[8] : word_w[9];
wire       stop2_ok = (frm_q == `URX_FRM_8N2) ? word_w[8] : 1'b1;
wire       frame_bad = !(stop1_ok & stop2_ok) | ((frm_q == `URX_FRM_8P1) & !par_ok);

always @(posedge i_sys_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      state_q   <= ST_IDLE;
      highs_q   <= 2'd0;
      phase_q   <= 4'd0;
      step_q    <= 4'd0;
      smp_q     <= 3'b000;
      shift_q   <= 10'h000;
      noise_q   <= 1'b0;
      ferr_q    <= 1'b0;
      frm_q     <= 2'b00;
      par_sel_q <= 1'b0;
   end else if (i_ce && tick) begin
      case (state_q)
         ST_IDLE: begin
            if (rx_s_q) begin
               if (highs_q != `URX_START_HIGHS) begin
                  highs_q <= highs_q + 2'd1;
               end
            end else if (highs_q == `URX_START_HIGHS) begin
               state_q   <= ST_BIT;
               phase_q   <= 4'd1;
               step_q    <= 4'd0;
               noise_q   <= 1'b0;
               frm_q     <= i_frame_format_select;
               par_sel_q <= i_parity_or_ninth_bit;
               highs_q   <= 2'd0;
            end else begin
               highs_q <= 2'd0;
            end
         end
         ST_BIT: begin
            phase_q <= phase_q + 4'd1;
            if (phase_q == `URX_VOTE_A) smp_q[0] <= rx_s_q;
            if (phase_q == `URX_VOTE_B) smp_q[1] <= rx_s_q;
            if (phase_q == `URX_VOTE_C) smp_q[2] <= rx_s_q;
            if (phase_q == 4'hf) begin
               if (step_q != 4'd0) begin
                  shift_q <= {vbit, shift_q[9:1]};
               end
               if (vnoisy) noise_q <= 1'b1;
               if (step_q == nsteps) begin
                  state_q <= ST_DONE;
               end
               step_q <= step_q + 4'd1;
            end
         end
         ST_DONE: begin
            ferr_q  <= frame_bad;
            state_q <= ST_IDLE;
         end
         default: state_q <= ST_IDLE;
      endcase
   end
end
////////////////////////////////////////////////////////////////////////
// break detector
always @(posedge i_sys_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      lows_q  <= 4'd0;
      o_break <= 1'b0;
   end else if (i_ce) begin
      o_break <= 1'b0;
      if (bit_end) begin
         if (vbit) begin
            lows_q <= 4'd0;
         end else if (lows_q == `URX_BREAK_BITS - 4'd1) begin
            lows_q  <= 4'd0;
            o_break <= 1'b1;
         end else begin
            lows_q <= lows_q + 4'd1;
         end
      end
   end
end
////////////////////////////////////////////////////////////////////////
// holding buffer and status
reg  [7:0] hold_q;
reg        hold9_q;
reg        full_q;
reg        ovr_q;
reg        noise_st_q;
reg        ferr_st_q;
reg        brk_pend_q;
wire       done     = i_ce && tick && (state_q == ST_DONE);
wire       rd_data  = i_ce && i_rd_en && (i_rd_addr == `URX_ADDR_DATA);
always @(posedge i_sys_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      hold_q     <= `URX_RST_BYTE;
      hold9_q    <= 1'b0;
      full_q     <= 1'b0;
      ovr_q      <= 1'b0;
      noise_st_q <= 1'b0;
      ferr_st_q  <= 1'b0;
      brk_pend_q <= 1'b0;
   end else if (i_ce) begin
      if (o_break) begin
         brk_pend_q <= 1'b1;
      end else if (rd_data) begin
         brk_pend_q <= 1'b0;
      end
      if (done && full_q && !rd_data) begin
         ovr_q <= 1'b1;
      end else if (done) begin
         hold_q     <= data_w;
         hold9_q    <= (frm_q == `URX_FRM_9N1) ? ninth_w : 1'b0;
         full_q     <= 1'b1;
         noise_st_q <= noise_q;
         ferr_st_q  <= frame_bad;
         ovr_q      <= 1'b0;
      end else if (rd_data) begin
         full_q <= 1'b0;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// read mux
always @(posedge i_sys_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      o_rd_data <= `URX_RST_BYTE;
   end else if (i_ce && i_rd_en) begin
      case (i_rd_addr)
         `URX_ADDR_DATA:   o_rd_data <= hold_q;
         `URX_ADDR_STATUS: o_rd_data <= {noise_st_q, ferr_st_q, full_q, ovr_q,
                                          1'b0, hold9_q, 2'b00};
         default:          o_rd_data <= 8'h00;
      endcase
   end
end
assign o_irq = i_serial_irq_global_mask &
               ((i_irq_full_en & full_q) | (i_irq_overrun_en & ovr_q) | (i_irq_break_en & brk_pend_q));
endmodule // urx_receiver

/* File: src/urx_tick_gen.v */
`timescale 1ns/1ns
module urx_tick_gen (
   // clock and reset
   input  wire        i_sys_clk,
   input  wire        i_rst_n,
   input  wire        i_ce,
   // divisor
   input  wire [11:0] i_div,
   // sample tick
   output wire        o_tick
);
`include "urx_consts.vh"
reg [11:0] cnt_q;
wire       wrap = (cnt_q == 12'h000);
assign o_tick = wrap & i_ce & (i_div != 12'h000);
always @(posedge i_sys_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      cnt_q <= `URX_RST_DIV;
   end else if (i_ce) begin
      if (wrap || i_div == 12'h000) begin
         cnt_q <= (i_div == 12'h000) ? 12'h000 : i_div - 12'h001;
      end else begin
         cnt_q <= cnt_q - 12'h001;
      end
   end
end
endmodule // urx_tick_gen

/* File: src/urx_vote.v */
`timescale 1ns/1ns
module urx_vote (
   // three samples
   input  wire [2:0] i_smp,
   // result
   output wire       o_bit,
   output wire       o_noisy
);
assign o_bit   = (i_smp[0] & i_smp[1]) | (i_smp[0] & i_smp[2]) | (i_smp[1] & i_smp[2]);
assign o_noisy = ~((&i_smp) | ~(|i_smp));
endmodule // urx_vote
